// [design/icr_shadow.sv]
`timescale 1ns/1ps
module icr_shadow
   import icr_pkg::*;
(
   input wire logic clk_in, // Core clock
   input wire logic rst_in, // Sync reset
   input wire logic save_in, // Capture strobe
   input wire icr_ctx_s ctx_in, // Live context
   output icr_ctx_s ctx_out // Saved context
);
   icr_ctx_s shadow_d;
   icr_ctx_s shadow_q;

   always_comb begin
      shadow_d = shadow_q;
      if (save_in) begin
         shadow_d = ctx_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         shadow_q <= '{pc: ICR_RST_PC, acc: ICR_RST_BYTE, status: ICR_RST_BYTE,
                       fsp: ICR_RST_BYTE};
      end else begin
         shadow_q <= shadow_d;
      end
   end

   assign ctx_out = shadow_q;
endmodule // icr_shadow

// [design/icr_unit.sv]
`timescale 1ns/1ps
module icr_unit
   import icr_pkg::*;
(
   input wire logic MCLK_IN, // 25 MHz core clock
   input wire logic RST_IN, // Sync reset, high
   input wire logic TURBO_IN, // High selects turbo mode
   input wire logic IRQ_TAKE_IN, // Pulse: take interrupt
   input wire logic OP_VALID_IN, // Pulse: opcode decoded
   input wire logic [11:0] OP_IN, // Decoded opcode
   input wire icr_ctx_s CTX_IN, // Live core context
   input wire logic [7:0] RTC_IN, // Live real-time counter
   output logic BUSY_OUT, // Return in progress
   output logic DONE_OUT, // Pulse: return finished
   output logic CTX_LOAD_OUT, // Pulse: load CTX_OUT into core
   output icr_ctx_s CTX_OUT, // Context to load
   output logic FETCH_LOAD_OUT, // Pulse: fetch from FETCH_PC_OUT
   output logic [11:0] FETCH_PC_OUT, // Redirected fetch address
   output logic RTC_LOAD_OUT, // Pulse: load RTC_OUT
   output logic [7:0] RTC_OUT // New real-time counter value
);
   // Sequencer: where a return stands and how many cycles remain
   icr_state_e state_d;
   icr_state_e state_q;
   logic [1:0] cnt_d;
   logic [1:0] cnt_q;
   logic busy_d;
   logic busy_q;

   // One-cycle strobes toward the core
   logic done_d;
   logic done_q;
   logic cl_d;
   logic cl_q;
   logic fl_d;
   logic fl_q;
   logic rl_d;
   logic rl_q;

   // Data that stands until its next update
   icr_ctx_s ctx_d;
   icr_ctx_s ctx_q;
   logic [11:0] fpc_d;
   logic [11:0] fpc_q;
   logic [7:0] rtc_d;
   logic [7:0] rtc_q;

   icr_ctx_s shadow;
   logic save;
   logic is_reti;
   logic is_retiw;
   logic is_ret;
   logic adjust;
   logic restore;
   logic [1:0] wait_cycles;
   logic [8:0] rtc_sum;

   // Interrupts are not taken while a return is completing
   assign save = IRQ_TAKE_IN && (state_q == ICR_IDLE);
   assign is_reti = OP_VALID_IN && (OP_IN == ICR_OP_RETI);
   assign is_retiw = OP_VALID_IN && (OP_IN == ICR_OP_RETIW);
   assign is_ret = is_reti || is_retiw;
   // Cycles beyond the compatible length; decode is the first cycle
   assign wait_cycles = (TURBO_IN ? ICR_CYC_TURBO : ICR_CYC_COMPAT) - ICR_CYC_COMPAT;
   // Ninth bit is the carry, dropped on purpose: status is rewritten anyway
   assign rtc_sum = {1'b0, RTC_IN} + {1'b0, CTX_IN.acc};

   icr_shadow u_shadow (
      .clk_in(MCLK_IN),
      .rst_in(RST_IN),
      .save_in(save),
      .ctx_in(CTX_IN),
      .ctx_out(shadow)
   );

   // Compatible mode: decode, then finish. Turbo adds one wait cycle,
   // which the adjust state fills when the counter must be corrected.
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      busy_d = busy_q;
      adjust = 1'b0;
      restore = 1'b0;
      unique case (state_q)
         ICR_IDLE: begin
            // Interrupt wins over a decode in the same cycle
            if (is_ret && !save) begin
               busy_d = 1'b1;
               cnt_d = wait_cycles;
               state_d = is_retiw ? ICR_ADJ : ICR_RET;
            end
         end
         ICR_ADJ: begin
            adjust = 1'b1;
            if (cnt_q == 2'h0) begin
               // No spare cycle: the sum is built from the routine's
               // accumulator, so it can share this cycle with the restore
               restore = 1'b1;
            end else begin
               cnt_d = cnt_q - 2'h1;
               state_d = ICR_RET;
            end
         end
         ICR_RET: begin
            if (cnt_q != 2'h0) begin
               cnt_d = cnt_q - 2'h1;
            end else begin
               restore = 1'b1;
            end
         end
         default: begin
            // Illegal one-hot code: fall back to idle
            state_d = ICR_IDLE;
            cnt_d = 2'h0;
            busy_d = 1'b0;
         end
      endcase
      // Restore closes the return in its last instruction cycle
      if (restore) begin
         busy_d = 1'b0;
         cnt_d = 2'h0;
         state_d = ICR_IDLE;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         state_q <= ICR_IDLE;
         cnt_q <= 2'h0;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         busy_q <= busy_d;
      end
   end

   // Save needs the idle state, so it never meets a restore
   always_comb begin
      done_d = 1'b0;
      cl_d = 1'b0;
      fl_d = 1'b0;
      rl_d = 1'b0;
      if (save) begin
         fl_d = 1'b1;
      end
      if (adjust) begin
         rl_d = 1'b1;
      end
      if (restore) begin
         done_d = 1'b1;
         cl_d = 1'b1;
         fl_d = 1'b1;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         done_q <= 1'b0;
         cl_q <= 1'b0;
         fl_q <= 1'b0;
         rl_q <= 1'b0;
      end else begin
         done_q <= done_d;
         cl_q <= cl_d;
         fl_q <= fl_d;
         rl_q <= rl_d;
      end
   end

   // Held values keep their last update for the core to read
   always_comb begin
      ctx_d = ctx_q;
      fpc_d = fpc_q;
      rtc_d = rtc_q;
      if (save) begin
         fpc_d = ICR_ISR_VECTOR;
      end
      if (adjust) begin
         rtc_d = rtc_sum[7:0];
      end
      if (restore) begin
         // Whole status byte comes back; the routine's flags are lost
         ctx_d = shadow;
         fpc_d = shadow.pc;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         ctx_q <= '{pc: ICR_RST_PC, acc: ICR_RST_BYTE, status: ICR_RST_BYTE,
                    fsp: ICR_RST_BYTE};
         fpc_q <= ICR_RST_PC;
         rtc_q <= ICR_RST_BYTE;
      end else begin
         ctx_q <= ctx_d;
         fpc_q <= fpc_d;
         rtc_q <= rtc_d;
      end
   end

   // Every output comes straight from its register
   assign BUSY_OUT = busy_q;
   assign DONE_OUT = done_q;
   assign CTX_LOAD_OUT = cl_q;
   assign CTX_OUT = ctx_q;
   assign FETCH_LOAD_OUT = fl_q;
   assign FETCH_PC_OUT = fpc_q;
   assign RTC_LOAD_OUT = rl_q;
   assign RTC_OUT = rtc_q;
endmodule // icr_unit

// [inc/icr_pkg.sv]
package icr_pkg;
   localparam int ICR_PC_W = 12;
   localparam int ICR_DW = 8;
   localparam int ICR_OP_W = 12;
   localparam logic [11:0] ICR_OP_RETI = 12'h00E;
   localparam logic [11:0] ICR_OP_RETIW = 12'h00F;
   localparam logic [11:0] ICR_ISR_VECTOR = 12'h000;
   localparam logic [1:0] ICR_CYC_COMPAT = 2'h2;
   localparam logic [1:0] ICR_CYC_TURBO = 2'h3;
   localparam logic [7:0] ICR_RST_BYTE = 8'h00;
   localparam logic [11:0] ICR_RST_PC = 12'h000;

   typedef struct packed {
      logic [11:0] pc;
      logic [7:0] acc;
      logic [7:0] status;
      logic [7:0] fsp;
   } icr_ctx_s;

   typedef enum logic [2:0] {
      ICR_IDLE = 3'b001,
      ICR_ADJ = 3'b010,
      ICR_RET = 3'b100
   } icr_state_e;
endpackage

// [tb/icr_unit_monitor.sv]
`timescale 1ns/1ps
module icr_unit_monitor
   import icr_pkg::*;
(
   input wire logic MCLK_IN, // Clock
   input wire logic RST_IN, // Reset
   input wire logic TURBO_IN, // Mode
   input wire logic IRQ_TAKE_IN, // Interrupt
   input wire logic OP_VALID_IN, // Decode
   input wire logic [11:0] OP_IN, // Opcode
   input wire icr_ctx_s CTX_IN, // Live
   input wire logic [7:0] RTC_IN, // Counter
   input wire logic BUSY_OUT, // Busy
   input wire logic DONE_OUT, // Done
   input wire logic CTX_LOAD_OUT, // Restore
   input wire icr_ctx_s CTX_OUT, // Restored
   input wire logic FETCH_LOAD_OUT, // Redirect
   input wire logic [11:0] FETCH_PC_OUT, // Target
   input wire logic RTC_LOAD_OUT, // Load
   input wire logic [7:0] RTC_OUT // Sum
);
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (RST_IN);
   icr_ctx_s sh_q;
   logic irq;
   logic ret;
   assign irq = IRQ_TAKE_IN && !BUSY_OUT;
   // Interrupt wins over a same-cycle decode
   assign ret = OP_VALID_IN && !BUSY_OUT && !IRQ_TAKE_IN;
   always_ff @(posedge MCLK_IN) if (irq) sh_q <= CTX_IN;
   chk_irq_vector: assert property (
      irq |=> FETCH_LOAD_OUT && (FETCH_PC_OUT == ICR_ISR_VECTOR))
      else $error("no vector fetch");
   chk_ctx_restore: assert property (
      CTX_LOAD_OUT |-> CTX_OUT == sh_q)
      else $error("bad restore");
   chk_pc_full: assert property (
      CTX_LOAD_OUT |-> FETCH_PC_OUT == sh_q.pc)
      else $error("bad return pc");
   chk_reti_compat: assert property (
      ret && (OP_IN == ICR_OP_RETI) && !TURBO_IN
      |=> BUSY_OUT ##1 DONE_OUT && !RTC_LOAD_OUT)
      else $error("compat return length");
   chk_retiw_compat: assert property (
      ret && (OP_IN == ICR_OP_RETIW) && !TURBO_IN |-> ##2 DONE_OUT && RTC_LOAD_OUT)
      else $error("compat adjust length");
   chk_turbo_len: assert property (
      ret && TURBO_IN && ((OP_IN == ICR_OP_RETI) || (OP_IN == ICR_OP_RETIW))
      |=> BUSY_OUT[*2] ##1 DONE_OUT)
      else $error("turbo return length");
   chk_rtc_sum: assert property (
      RTC_LOAD_OUT |-> RTC_OUT == 8'($past(RTC_IN) + $past(CTX_IN.acc)))
      else $error("bad counter sum");
   chk_done_pair: assert property (DONE_OUT |-> CTX_LOAD_OUT && FETCH_LOAD_OUT && !BUSY_OUT)
      else $error("done without restore");
   cover property (RTC_LOAD_OUT && DONE_OUT);
   cover property (DONE_OUT && TURBO_IN);
   cover property (irq);
endmodule // icr_unit_monitor
bind icr_unit icr_unit_monitor mon_u (.*);

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   import icr_pkg::*;
   logic clk = 0, rst = 1, turbo = 0, irq = 0, opv = 0;
   logic [11:0] op = 12'h000;
   logic [7:0] rtc = 8'h00;
   icr_ctx_s ctx = '0;
   logic busy, done, cl, fl, rl;
   icr_ctx_s co;
   logic [11:0] fpc;
   logic [7:0] ro;
   int n_errors = 0, checks = 0, n;
   icr_ctx_s q[$];
   icr_ctx_s a;
   always #20 clk = ~clk;
   icr_unit dut_u (.MCLK_IN(clk), .RST_IN(rst), .TURBO_IN(turbo), .IRQ_TAKE_IN(irq),
      .OP_VALID_IN(opv), .OP_IN(op), .CTX_IN(ctx), .RTC_IN(rtc), .BUSY_OUT(busy),
      .DONE_OUT(done), .CTX_LOAD_OUT(cl), .CTX_OUT(co), .FETCH_LOAD_OUT(fl),
      .FETCH_PC_OUT(fpc), .RTC_LOAD_OUT(rl), .RTC_OUT(ro));
   task automatic chk(input logic [35:0] g, input logic [35:0] e);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic close_out;
      $display("checks=%0d errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      close_out;
   end
   initial begin
      void'($urandom(32'h2ec9));
      repeat (4) @(posedge clk);
      rst <= 0;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         a = 36'({$urandom, $urandom});
         q.push_back(a);
         irq <= 1;
         ctx <= a;
         @(posedge clk);
         irq <= 0;
         ctx <= 36'({$urandom, $urandom});
         #1;
         chk(fl, 1);
         chk(fpc, ICR_ISR_VECTOR);
         @(posedge clk);
         turbo <= i[0];
         op <= i[1] ? ICR_OP_RETIW : ICR_OP_RETI;
         opv <= 1;
         rtc <= 8'($urandom);
         n = i[0] ? 3 : 2;
         // Stray interrupt and decode while busy must change nothing
         for (int k = 1; k < 5; k++) begin
            @(posedge clk);
            irq <= k == 1;
            opv <= k == 1;
            #1;
            chk(done, k == n);
            chk(rl, i[1] && k == 2);
            chk(busy, k < n);
            chk(cl, k == n);
            chk(fl, k == n);
         end
         a = q.pop_front();
         chk(co, a);
         chk(fpc, a.pc);
         if (i[1]) chk(ro, 8'(rtc + ctx.acc));
         $display("test %0d done", i);
      end
      close_out;
   end
endmodule // tb_top
